// [src/clkgen_status_regs.v]
// status-control and auxiliary register slice of a programmable clock generator
//
// Notes on behaviour
// - bit 15 set: calibrate gain at power-up
// - bit 10 reports clock ready; pin mirrors it
// - bit 9 flags fuse programming checksum error
// - bit 8 reads reference control pin level
// - bit 7 reads select1/data pin level
// - bit 6 reads select0/clock pin level
// - bit 5 reads format/address pin level
// - idle select one (reset): mute, stay powered
// - bit 1 forces analog power-down
// - auxiliary bits 8:1 are spare read-write byte
// - aux bit 0 gates unused dividers in calibration
`include "clkgen_regs_defines.vh"
`default_nettype none
module clkgen_status_regs #(
  parameter [3:0] REVISION = 4'h3  // arbitrary neutral revision value
) (
  input  wire                clk_i,
  input  wire                rst_i,
  input  wire                wr_en_i,
  input  wire                rd_en_i,
  input  wire [`ADDR_W-1:0]  addr_i,
  input  wire [`DATA_W-1:0]  wdata_i,
  output reg  [`DATA_W-1:0]  rdata_o,
  output wire                addr_hit_o,
  input  wire                clk_ready_i,
  input  wire                crc_error_i,
  input  wire                refctl_is_ready_out_i,
  input  wire                refctl_pin_i,
  input  wire                config_select_bit1_pin_i,
  input  wire                config_select_bit0_pin_i,
  input  wire                format_address_pin_i,
  input  wire                out0_enable_i,
  input  wire                out1_enable_i,
  input  wire                calib_active_i,
  output wire                refctl_pin_o,
  output wire                refctl_pin_oe_o,
  output reg                 powerup_gain_calib_enable_o,
  output reg                 analog_powerdown_o,
  output reg                 outputs_muted_o,
  output reg                 low_power_idle_o,
  output reg                 unused_divider_disable_o,
  output reg [`SPARE_W-1:0]  spare_byte_o
);
  // =====================================================
  // address decode
  // the same compare serves both words, so it lives in one function;
  // decode is purely combinational and settles within the cycle in
  // which the strobe is presented
  // addr_hit_o lets the bus front end answer only for offsets that
  // this slice owns; every other offset belongs to another slice
  function is_addr;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  wire sel_status = is_addr(addr_i, `OFF_STATUS_CONTROL);
  wire sel_aux    = is_addr(addr_i, `OFF_AUX_SPARE);
  assign addr_hit_o = sel_status | sel_aux;

  // =====================================================
  // writable storage
  // both words share one storage module; the write mask keeps the
  // hardware-owned bits at their reset value inside the storage, so
  // a host write of all ones cannot leave a stale copy of a status bit
  // reserved bit 3 stays stored as plain read-write, while bits 2 and 0
  // are masked off and always read zero
  wire [`DATA_W-1:0] status_q;
  wire [`DATA_W-1:0] aux_q;

  // only bits 15, 4, 3, 1 of the status word are stored
  reg_word #(
    .RESET_VAL (`RST_STATUS_CONTROL),
    .WR_MASK   (`RW_MASK_STATUS)
  ) u_status (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (wr_en_i & sel_status),
    .wdata_i (wdata_i),
    .q_o     (status_q)
  );

  // whole auxiliary word is plain read-write
  reg_word #(
    .RESET_VAL (`RST_AUX_SPARE),
    .WR_MASK   (`RW_MASK_AUX)
  ) u_aux (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (wr_en_i & sel_aux),
    .wdata_i (wdata_i),
    .q_o     (aux_q)
  );

  // =====================================================
  // live status view, read-only bits come from hardware
  // pin levels are taken as already synchronous to clk_i; a pin that
  // toggles right at a read edge shows either level, never a glitch,
  // because the read data is captured in a register below
  // the revision field is a constant of the build, not stored state
  reg [`DATA_W-1:0] status_view;
  always @*
  begin
    status_view = status_q;
    status_view[`FLD_REV_HI:`FLD_REV_LO] = REVISION;
    status_view[`BIT_CLK_READY]  = clk_ready_i;
    status_view[`BIT_CRC_ERROR]  = crc_error_i;
    status_view[`BIT_REFCTL_PIN] = refctl_pin_i;
    status_view[`BIT_SEL1_PIN]   = config_select_bit1_pin_i;
    status_view[`BIT_SEL0_PIN]   = config_select_bit0_pin_i;
    status_view[`BIT_FMT_PIN]    = format_address_pin_i;
  end

  // =====================================================
  // read data, registered; unmapped offsets read zero
  // read data holds until the next read so a slow serial front end can
  // shift it out at leisure; a read in the cycle of a write returns the
  // old word, since storage updates on the same edge
  always @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= `RST_RDATA;
    else if (rd_en_i)
      rdata_o <= sel_status ? status_view : (sel_aux ? aux_q : `UNMAPPED_RDATA);
  end

  // =====================================================
  // reference control pin mirrors clock-ready when configured so
  // the pin value is driven all the time; only the enable decides
  // whether it reaches the pad, so switching the pin function cannot
  // produce a short pulse of a stale level
  assign refctl_pin_o    = clk_ready_i;
  assign refctl_pin_oe_o = refctl_is_ready_out_i;

  // =====================================================
  // control outputs toward the rest of the unit
  // every control is registered so the analog side never sees a glitch
  // from the address decode; the cost is one cycle of extra latency
  wire both_off = ~out0_enable_i & ~out1_enable_i;

  // calibration request follows the stored enable bit; the power-up
  // sequencer samples it, so a late write acts on the next power-up
  always @(posedge clk_i)
  begin
    if (rst_i)
      powerup_gain_calib_enable_o <= `RST_BIT;
    else
      powerup_gain_calib_enable_o <= status_q[`BIT_GAIN_CAL_EN];
  end

  // forced analog power-down; downstream it overrides every other control
  always @(posedge clk_i)
  begin
    if (rst_i)
      analog_powerdown_o <= `RST_BIT;
    else
      analog_powerdown_o <= status_q[`BIT_PDN];
  end

  // muting follows the two enables whatever the idle select says
  always @(posedge clk_i)
  begin
    if (rst_i)
      outputs_muted_o <= `RST_BIT;
    else
      outputs_muted_o <= both_off;
  end

  // low power only when idle select is zero; one keeps analog alive,
  // trading idle current for a quick restart of the clocks
  always @(posedge clk_i)
  begin
    if (rst_i)
      low_power_idle_o <= `RST_BIT;
    else
      low_power_idle_o <= both_off & ~status_q[`BIT_IDLE_SEL];
  end

  // divider gating only matters while calibration runs
  always @(posedge clk_i)
  begin
    if (rst_i)
      unused_divider_disable_o <= `RST_BIT;
    else
      unused_divider_disable_o <= calib_active_i & aux_q[`BIT_CALMODE];
  end

  // spare byte has no function inside the unit; it is exported only so
  // firmware markers can be probed from outside
  always @(posedge clk_i)
  begin
    if (rst_i)
      spare_byte_o <= `RST_SPARE_BYTE;
    else
      spare_byte_o <= aux_q[`FLD_SPARE_HI:`FLD_SPARE_LO];
  end
endmodule
`default_nettype wire

// [src/clkgen_regs_defines.vh]
// register offsets, field positions and reset values of the clock generator status-control slice
`ifndef CLKGEN_REGS_DEFINES_VH
`define CLKGEN_REGS_DEFINES_VH
`define ADDR_W             8
`define DATA_W             16
`define OFF_STATUS_CONTROL 8'h0a
`define OFF_AUX_SPARE      8'h0b
`define RST_STATUS_CONTROL 16'h0010
`define RST_AUX_SPARE      16'h0000
`define BIT_GAIN_CAL_EN    15
`define FLD_REV_HI         14
`define FLD_REV_LO         11
`define BIT_CLK_READY      10
`define BIT_CRC_ERROR      9
`define BIT_REFCTL_PIN     8
`define BIT_SEL1_PIN       7
`define BIT_SEL0_PIN       6
`define BIT_FMT_PIN        5
`define BIT_IDLE_SEL       4
`define BIT_PDN            1
`define BIT_CALMODE        0
`define FLD_SPARE_HI       8
`define FLD_SPARE_LO       1
`define SPARE_W            8
`define REV_W              4
`define RW_MASK_STATUS     16'h801a
`define RW_MASK_AUX        16'hffff
`define RST_RDATA          16'h0000
`define UNMAPPED_RDATA     16'h0000
`define RST_SPARE_BYTE     8'h00
`define RST_BIT            1'b0
`endif

// [src/reg_word.v]
// one 16-bit storage word with per-bit write mask and registered value
`default_nettype none
module reg_word #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] WR_MASK   = 16'hffff
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        we_i,
  input  wire [15:0] wdata_i,
  output reg  [15:0] q_o
);
  // =====================================================
  // storage
  // masked bits keep their reset value, so writes cannot disturb them
  always @(posedge clk_i)
  begin
    if (rst_i)
      q_o <= RESET_VAL;
    else if (we_i)
      q_o <= (wdata_i & WR_MASK) | (q_o & ~WR_MASK);
  end
endmodule
`default_nettype wire

// [tb/clkgen_checker.sv]
// port checks for the status-control slice
`default_nettype none
module clkgen_checker (
  input wire logic        clk_i, rst_i, wr_en_i, rd_en_i, clk_ready_i, calib_active_i,
  input wire logic        out0_enable_i, out1_enable_i, refctl_pin_o, outputs_muted_o,
  input wire logic        powerup_gain_calib_enable_o, analog_powerdown_o,
  input wire logic        low_power_idle_o, unused_divider_disable_o,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i, rdata_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_PIN: assert property (refctl_pin_o == clk_ready_i)
    else $error("pin differs from ready");
  AST_MUTE: assert property (!out0_enable_i && !out1_enable_i |=> outputs_muted_o)
    else $error("not muted");
  AST_AWAKE: assert property (out0_enable_i || out1_enable_i |=> !low_power_idle_o)
    else $error("low power while enabled");
  AST_GATE: assert property (!calib_active_i |=> !unused_divider_disable_o)
    else $error("gate outside calibration");
  AST_PDN: assert property (wr_en_i && addr_i == 8'h0a && wdata_i[1]
    |-> ##[1:2] analog_powerdown_o)
    else $error("no power-down");
  AST_CAL: assert property (wr_en_i && addr_i == 8'h0a && wdata_i[15]
    |-> ##[1:2] powerup_gain_calib_enable_o)
    else $error("no calibration enable");
  AST_RD: assert property (rd_en_i && addr_i == 8'h0a
    |=> rdata_o[10] == $past(clk_ready_i))
    else $error("ready bit wrong");
  AST_RSV: assert property (rd_en_i && addr_i == 8'h0a |=> !rdata_o[2] && !rdata_o[0])
    else $error("reserved bit set");
endmodule
bind clkgen_status_regs clkgen_checker clkgen_checker_i (.*);
`default_nettype wire

// [tb/host_model.sv]
// serial host stand-in issuing register writes and reads
`default_nettype none
module host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output var logic         wr_o = 1'b0, rd_o = 1'b0,
  output var logic [7:0]   addr_o = 8'h00,
  output var logic [15:0]  wdata_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // released data is inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= (a == 8'h0a) ? (d & 16'hfff2) : d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the status-control slice
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, refctl_is_ready_out_i = 0, out0_enable_i = 1, out1_enable_i = 1;
  logic calib_active_i = 0, wr_en_i, rd_en_i, addr_hit_o, refctl_pin_o, refctl_pin_oe_o;
  logic powerup_gain_calib_enable_o, analog_powerdown_o, outputs_muted_o, low_power_idle_o;
  logic unused_divider_disable_o;
  logic [5:0] pv = 6'h00;
  logic [7:0] addr_i, spare_byte_o;
  logic [15:0] wdata_i, rdata_o, v;
  wire clk_ready_i, crc_error_i, refctl_pin_i, config_select_bit1_pin_i;
  wire config_select_bit0_pin_i, format_address_pin_i;
  int miscompares = 0, n_checks = 0;
  // live status inputs packed in read-back order, bits 10 down to 5
  assign {clk_ready_i, crc_error_i, refctl_pin_i, config_select_bit1_pin_i,
          config_select_bit0_pin_i, format_address_pin_i} = pv;
  clkgen_status_regs #(.REVISION(4'h5)) clkgen_status_regs_i (.*);
  host_model host_model_i (.clk_i(clk_i), .rdata_i(rdata_o), .wr_o(wr_en_i), .rd_o(rd_en_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  initial forever #25 clk_i = ~clk_i;
  task chk(input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // status word seen by a read: stored bits plus revision and live inputs
  function automatic logic [15:0] st(input logic [15:0] m);
    return m | {1'b0, 4'h5, pv, 5'h00};
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset values, then each live input alone
  task t_pins;
    host_model_i.rd(8'h0a, v);
    chk(v, st(16'h0010));
    host_model_i.rd(8'h0b, v);
    chk(v, 16'h0000);
    refctl_is_ready_out_i <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i) pv <= 6'h01 << i;
      host_model_i.rd(8'h0a, v);
      chk(v, st(16'h0010));
      chk({refctl_pin_oe_o, refctl_pin_o}, {1'b1, pv[5]});
    end
  endtask
  // all ones, masked to fff2 by the host: only bits 15, 4, 1 stick
  task t_write;
    host_model_i.wr(8'h0a, 16'hffff);
    repeat (2) @(posedge clk_i);
    #1 chk({powerup_gain_calib_enable_o, analog_powerdown_o}, 16'h0003);
    host_model_i.rd(8'h0a, v);
    chk(v, st(16'h8012));
  endtask
  // both outputs off, idle select one then zero
  task t_idle;
    @(posedge clk_i) {out0_enable_i, out1_enable_i} <= 2'b00;
    repeat (2) @(posedge clk_i);
    #1 chk({outputs_muted_o, low_power_idle_o}, 16'h0002);
    host_model_i.wr(8'h0a, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1 chk({outputs_muted_o, low_power_idle_o, analog_powerdown_o}, 16'h0006);
    // back to the stay-powered idle that fast links want
    host_model_i.wr(8'h0a, 16'h0010);
    repeat (2) @(posedge clk_i);
    #1 chk({outputs_muted_o, low_power_idle_o}, 16'h0002);
  endtask
  // spare byte, divider gate in calibration, unmapped read
  task t_aux;
    host_model_i.wr(8'h0b, 16'h01ff);
    @(posedge clk_i) calib_active_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk({spare_byte_o, unused_divider_disable_o}, 16'h01ff);
    host_model_i.rd(8'h0b, v);
    chk(v, 16'h01ff);
    chk(addr_hit_o, 16'h0001);
    host_model_i.wr(8'h0b, 16'h01fe);
    repeat (2) @(posedge clk_i);
    #1 chk({spare_byte_o, unused_divider_disable_o}, 16'h01fe);
    host_model_i.rd(8'h0c, v);
    chk(v, 16'h0000);
    chk(addr_hit_o, 16'h0000);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_pins;
    t_write;
    t_idle;
    t_aux;
    stop_test;
  end
  initial
  begin
    #200000;
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
